// >>> asd_pkg.sv
`default_nettype none
package asd_pkg;

  // ****************************************************
  // Register map (byte addresses on the APB side)
  // ****************************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_INSTR   = 8'h04;
  localparam logic [7:0] OFF_OPND1   = 8'h08;
  localparam logic [7:0] OFF_SHSRC   = 8'h0C;
  localparam logic [7:0] OFF_SHAMT   = 8'h10;
  localparam logic [7:0] OFF_IADDR   = 8'h14;
  localparam logic [7:0] OFF_CUR_SR  = 8'h18;
  localparam logic [7:0] OFF_SAV_SR  = 8'h1C;
  localparam logic [7:0] OFF_RESULT  = 8'h20;
  localparam logic [7:0] OFF_STATUS  = 8'h24;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic        RST_CONDOK = 1'b1;

  // ****************************************************
  // Control and status fields
  // ****************************************************
  localparam int CTL_START    = 0;
  localparam int CTL_CONDOK   = 1;
  localparam int FLAG_LSB     = 28;

  // ****************************************************
  // Instruction word fields
  // ****************************************************
  localparam int INS_CLASS_LSB = 26;
  localparam int INS_IMM       = 25;
  localparam int INS_OP_LSB    = 21;
  localparam int INS_SETFL     = 20;
  localparam int INS_RN_LSB    = 16;
  localparam int INS_RD_LSB    = 12;
  localparam int INS_ROT_LSB   = 8;
  localparam int INS_SHIMM_LSB = 7;
  localparam int INS_MULSEL    = 7;
  localparam int INS_SHTY_LSB  = 5;
  localparam int INS_REGSH     = 4;
  localparam int INS_RM_LSB    = 0;
  localparam logic [1:0] CLASS_DATA = 2'b00;
  localparam logic [3:0] PC_INDEX   = 4'hF;

  // ****************************************************
  // Program counter read-ahead and cycle counts
  // ****************************************************
  localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000C;
  localparam logic [7:0]  SH_FULL      = 8'h20;
  localparam logic [3:0]  FETCH_NORMAL = 4'h1;
  localparam logic [3:0]  FETCH_PCWR   = 4'h3;
  localparam logic [3:0]  INT_REGSH    = 4'h1;
  localparam logic [3:0]  INT_NONE     = 4'h0;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [3:0] {
    OP_AND = 4'h0, OP_XOR = 4'h1, OP_SUB  = 4'h2, OP_RSUB = 4'h3,
    OP_ADD = 4'h4, OP_ADC = 4'h5, OP_SBC  = 4'h6, OP_RSC  = 4'h7,
    OP_TST = 4'h8, OP_TXR = 4'h9, OP_CMP  = 4'hA, OP_CMN  = 4'hB,
    OP_OR  = 4'hC, OP_MOV = 4'hD, OP_ANDN = 4'hE, OP_MOVN = 4'hF
  } asd_op_e;

  typedef enum logic [1:0] {
    SH_LSL = 2'b00, SH_LSR = 2'b01, SH_ASR = 2'b10, SH_ROR = 2'b11
  } asd_shift_e;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } asd_flags_s;

  typedef struct packed {
    logic [31:0] res;
    asd_flags_s  fl;
  } asd_alu_s;

  typedef struct packed {
    logic       restore;
    logic       pc_wr;
    logic       undef;
    logic       rd_wr;
    logic [3:0] fetches;
    logic [3:0] internal;
  } asd_exec_s;

  // Status word bit positions
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_RDWR      = 2;
  localparam int ST_UNDEF     = 3;
  localparam int ST_PCWR      = 4;
  localparam int ST_RESTORE   = 5;
  localparam int ST_FETCH_LSB = 8;
  localparam int ST_INT_LSB   = 12;

endpackage
`default_nettype wire

// >>> asd_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module asd_datapath #(
  parameter int unsigned FETCH_CYCLES = 1
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Execution status
  output logic             busy
);

  // ****************************************************
  // Elaboration check
  // ****************************************************
  // The run counter is five bits wide: three fetches plus one must fit
  if (FETCH_CYCLES < 1 || FETCH_CYCLES > 7) begin : g_bad_fetch
    $error("FETCH_CYCLES must lie between 1 and 7");
  end

  // ****************************************************
  // Functions
  // ****************************************************
  // Merge write data into a register under the byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Barrel shifter; returns {carry, value}
  function automatic logic [32:0] shift_op(input asd_pkg::asd_shift_e ty,
                                           input logic [7:0]  amt,
                                           input logic [31:0] v,
                                           input logic        c,
                                           input logic        imm);
    logic [7:0]  n;
    logic [32:0] w;
    logic [63:0] rr;
    logic [32:0] out;
    logic        spec;
    n    = amt;
    out  = {c, v};
    spec = 1'b0;
    w    = 33'h0_0000_0000;
    rr   = {v, v};
    if (imm && n == 8'h00) begin
      if (ty == asd_pkg::SH_LSR || ty == asd_pkg::SH_ASR) begin
        n = asd_pkg::SH_FULL;
      end else if (ty == asd_pkg::SH_ROR) begin
        out  = {v[0], c, v[31:1]};
        spec = 1'b1;
      end
    end
    // Same arithmetic serves both amount sources for 1..31
    if (!spec && n != 8'h00) begin
      case (ty)
        asd_pkg::SH_LSL: begin
          if (n <= asd_pkg::SH_FULL) begin
            w   = {1'b0, v} << n;
            out = w;
          end else begin
            out = 33'h0_0000_0000;
          end
        end
        asd_pkg::SH_LSR: begin
          if (n <= asd_pkg::SH_FULL) begin
            w   = {v, 1'b0} >> n;
            out = {w[0], w[32:1]};
          end else begin
            out = 33'h0_0000_0000;
          end
        end
        asd_pkg::SH_ASR: begin
          if (n >= asd_pkg::SH_FULL) begin
            out = {33{v[31]}};
          end else begin
            w   = $signed({v, 1'b0}) >>> n;
            out = {w[0], w[32:1]};
          end
        end
        default: begin
          // Rotation wraps every 32, so only the low five bits matter
          if (n[4:0] == 5'h00) begin
            out = {v[31], v};
          end else begin
            rr  = {v, v} >> n[4:0];
            out = {rr[31], rr[31:0]};
          end
        end
      endcase
    end
    return out;
  endfunction

  // Rotated immediate; returns {carry, value}
  function automatic logic [32:0] imm_op(input logic [7:0] imm8,
                                         input logic [3:0] rot,
                                         input logic       c);
    logic [63:0] rr;
    logic [4:0]  amt;
    amt = {rot, 1'b0};
    rr  = {24'h00_0000, imm8, 24'h00_0000, imm8} >> amt;
    // No rotation keeps the old carry, otherwise bit 31 is the carry
    return {(amt == 5'h00) ? c : rr[31], rr[31:0]};
  endfunction

  // Sixteen-operation unit with flag generation
  function automatic asd_pkg::asd_alu_s alu_op(input asd_pkg::asd_op_e op,
                                               input logic [31:0] a,
                                               input logic [31:0] b,
                                               input asd_pkg::asd_flags_s f,
                                               input logic shc);
    logic [31:0]       x;
    logic [31:0]       y;
    logic              cin;
    logic              arith;
    logic [32:0]       sum;
    asd_pkg::asd_alu_s o;
    x     = a;
    y     = b;
    cin   = 1'b0;
    arith = 1'b1;
    case (op)
      asd_pkg::OP_SUB, asd_pkg::OP_CMP: begin
        y   = ~b;
        cin = 1'b1;
      end
      asd_pkg::OP_RSUB: begin
        x   = b;
        y   = ~a;
        cin = 1'b1;
      end
      asd_pkg::OP_ADD, asd_pkg::OP_CMN: begin
        cin = 1'b0;
      end
      asd_pkg::OP_ADC: begin
        cin = f.c;
      end
      asd_pkg::OP_SBC: begin
        y   = ~b;
        cin = f.c;
      end
      asd_pkg::OP_RSC: begin
        x   = b;
        y   = ~a;
        cin = f.c;
      end
      default: begin
        arith = 1'b0;
      end
    endcase
    sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
    case (op)
      asd_pkg::OP_AND, asd_pkg::OP_TST: o.res = a & b;
      asd_pkg::OP_XOR, asd_pkg::OP_TXR: o.res = a ^ b;
      asd_pkg::OP_OR:                   o.res = a | b;
      asd_pkg::OP_MOV:                  o.res = b;
      asd_pkg::OP_ANDN:                 o.res = a & ~b;
      asd_pkg::OP_MOVN:                 o.res = ~b;
      default:                          o.res = sum[31:0];
    endcase
    o.fl.n = o.res[31];
    o.fl.z = (o.res == asd_pkg::RST_ZERO);
    if (arith) begin
      o.fl.c = sum[32];
      o.fl.v = (x[31] == y[31]) && (o.res[31] != x[31]);
    end else begin
      o.fl.c = shc;
      o.fl.v = f.v;
    end
    return o;
  endfunction

  // ****************************************************
  // Registers and state
  // ****************************************************
  typedef enum logic {ST_IDLE, ST_RUN} asd_state_e;

  asd_state_e        state;
  logic              cond_ok;
  logic              done;
  logic [31:0]       instr;
  logic [31:0]       opnd1;
  logic [31:0]       shsrc;
  logic [31:0]       shamt;
  logic [31:0]       iaddr;
  logic [31:0]       cur_sr;
  logic [31:0]       sav_sr;
  logic [31:0]       result;
  logic [4:0]        run_cnt;
  asd_pkg::asd_exec_s last;

  // ****************************************************
  // Instruction decode
  // ****************************************************
  wire asd_pkg::asd_op_e    op     =
    asd_pkg::asd_op_e'(instr[asd_pkg::INS_OP_LSB +: 4]);
  wire asd_pkg::asd_shift_e sh_ty  =
    asd_pkg::asd_shift_e'(instr[asd_pkg::INS_SHTY_LSB +: 2]);
  wire asd_pkg::asd_flags_s cur_fl =
    asd_pkg::asd_flags_s'(cur_sr[asd_pkg::FLAG_LSB +: 4]);
  wire logic [3:0] rn_idx = instr[asd_pkg::INS_RN_LSB +: 4];
  wire logic [3:0] rd_idx = instr[asd_pkg::INS_RD_LSB +: 4];
  wire logic [3:0] rm_idx = instr[asd_pkg::INS_RM_LSB +: 4];
  wire logic is_imm = instr[asd_pkg::INS_IMM];
  wire logic set_fl = instr[asd_pkg::INS_SETFL];
  wire logic regsh  = !is_imm && instr[asd_pkg::INS_REGSH];
  wire logic test_op = (op[3:2] == 2'b10);
  wire logic rd_pc  = (rd_idx == asd_pkg::PC_INDEX);
  // Bit 7 set under a register shift belongs to another class
  wire logic bad = (regsh && instr[asd_pkg::INS_MULSEL]) ||
    (instr[asd_pkg::INS_CLASS_LSB +: 2] != asd_pkg::CLASS_DATA);

  // Program counter as operand reads ahead of the instruction address
  wire logic [31:0] pc_val = iaddr + (regsh ? asd_pkg::PC_AHEAD_REG
                                            : asd_pkg::PC_AHEAD_IMM);
  wire logic [31:0] op1_val = (rn_idx == asd_pkg::PC_INDEX) ? pc_val
                                                            : opnd1;
  wire logic [31:0] rm_val  = (rm_idx == asd_pkg::PC_INDEX) ? pc_val
                                                            : shsrc;

  // ****************************************************
  // Second operand and ALU
  // ****************************************************
  // Amount comes from the five-bit field or the register's low byte
  wire logic [7:0] sh_amt = regsh ? shamt[7:0]
    : {3'b000, instr[asd_pkg::INS_SHIMM_LSB +: 5]};
  wire logic [32:0] sh_out = shift_op(sh_ty, sh_amt, rm_val, cur_fl.c,
                                      !regsh);
  wire logic [32:0] im_out = imm_op(instr[7:0],
                                    instr[asd_pkg::INS_ROT_LSB +: 4],
                                    cur_fl.c);
  wire logic [32:0] op2    = is_imm ? im_out : sh_out;
  wire asd_pkg::asd_alu_s alu = alu_op(op, op1_val, op2[31:0], cur_fl,
                                       op2[32]);

  // ****************************************************
  // Commit decisions and cycle cost
  // ****************************************************
  wire logic exec     = cond_ok && !bad;
  wire logic wr_rd    = exec && !test_op;
  wire logic pc_wr    = wr_rd && rd_pc;
  wire logic flag_upd = exec && set_fl && !rd_pc;
  wire logic restore  = exec && set_fl && rd_pc;
  wire logic [3:0] fetches  = pc_wr ? asd_pkg::FETCH_PCWR
                                    : asd_pkg::FETCH_NORMAL;
  wire logic [3:0] internal = (exec && regsh) ? asd_pkg::INT_REGSH
                                              : asd_pkg::INT_NONE;
  wire logic [4:0] total = 5'(fetches * FETCH_CYCLES) + {1'b0, internal};

  // ****************************************************
  // APB decode
  // ****************************************************
  wire logic access  = psel && penable && !pready;
  wire logic wr_fire = psel && penable && pready && pwrite;
  wire logic sel_ctrl   = (paddr == asd_pkg::OFF_CTRL);
  wire logic sel_instr  = (paddr == asd_pkg::OFF_INSTR);
  wire logic sel_opnd1  = (paddr == asd_pkg::OFF_OPND1);
  wire logic sel_shsrc  = (paddr == asd_pkg::OFF_SHSRC);
  wire logic sel_shamt  = (paddr == asd_pkg::OFF_SHAMT);
  wire logic sel_iaddr  = (paddr == asd_pkg::OFF_IADDR);
  wire logic sel_cur_sr = (paddr == asd_pkg::OFF_CUR_SR);
  wire logic sel_sav_sr = (paddr == asd_pkg::OFF_SAV_SR);
  wire logic start = wr_fire && sel_ctrl && pstrb[0] &&
                     pwdata[asd_pkg::CTL_START] && (state == ST_IDLE);

  // Status word assembled from the last committed instruction
  wire logic [31:0] status_word = {16'h0000,
    last.internal, last.fetches, 2'b00,
    last.restore, last.pc_wr, last.undef, last.rd_wr, done, busy};

  // Read selection and address check
  logic [31:0] rd_mux;
  logic        hit;
  always_comb begin
    hit    = 1'b1;
    rd_mux = asd_pkg::RST_ZERO;
    if (sel_ctrl) begin
      rd_mux[asd_pkg::CTL_CONDOK] = cond_ok;
    end else if (sel_instr) begin
      rd_mux = instr;
    end else if (sel_opnd1) begin
      rd_mux = opnd1;
    end else if (sel_shsrc) begin
      rd_mux = shsrc;
    end else if (sel_shamt) begin
      rd_mux = shamt;
    end else if (sel_iaddr) begin
      rd_mux = iaddr;
    end else if (sel_cur_sr) begin
      rd_mux = cur_sr;
    end else if (sel_sav_sr) begin
      rd_mux = sav_sr;
    end else if (paddr == asd_pkg::OFF_RESULT) begin
      rd_mux = result;
    end else if (paddr == asd_pkg::OFF_STATUS) begin
      rd_mux = status_word;
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************************
  // APB answer, one wait state
  // ****************************************************
  // Registered answer keeps every bus output straight off a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= asd_pkg::RST_ZERO;
    end else begin
      pready  <= access;
      pslverr <= access && !hit;
      prdata  <= (access && !pwrite) ? rd_mux : asd_pkg::RST_ZERO;
    end
  end

  // ****************************************************
  // Software-written operand registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr   <= asd_pkg::RST_ZERO;
      opnd1   <= asd_pkg::RST_ZERO;
      shsrc   <= asd_pkg::RST_ZERO;
      shamt   <= asd_pkg::RST_ZERO;
      iaddr   <= asd_pkg::RST_ZERO;
      sav_sr  <= asd_pkg::RST_ZERO;
      cond_ok <= asd_pkg::RST_CONDOK;
    end else if (wr_fire) begin
      if (sel_instr)  instr  <= apply_strb(instr, pwdata, pstrb);
      if (sel_opnd1)  opnd1  <= apply_strb(opnd1, pwdata, pstrb);
      if (sel_shsrc)  shsrc  <= apply_strb(shsrc, pwdata, pstrb);
      if (sel_shamt)  shamt  <= apply_strb(shamt, pwdata, pstrb);
      if (sel_iaddr)  iaddr  <= apply_strb(iaddr, pwdata, pstrb);
      if (sel_sav_sr) sav_sr <= apply_strb(sav_sr, pwdata, pstrb);
      if (sel_ctrl && pstrb[0]) cond_ok <= pwdata[asd_pkg::CTL_CONDOK];
    end
  end

  // ****************************************************
  // Current status register
  // ****************************************************
  // Hardware update has priority over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_sr <= asd_pkg::RST_ZERO;
    end else if (start && restore) begin
      cur_sr <= sav_sr;
    end else if (start && flag_upd) begin
      cur_sr[asd_pkg::FLAG_LSB +: 4] <= alu.fl;
    end else if (wr_fire && sel_cur_sr) begin
      cur_sr <= apply_strb(cur_sr, pwdata, pstrb);
    end
  end

  // ****************************************************
  // Destination value and commit record
  // ****************************************************
  // Result keeps its old value when nothing is written back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= asd_pkg::RST_ZERO;
      last   <= '0;
    end else if (start) begin
      if (wr_rd) result <= alu.res;
      last <= '{restore: restore, pc_wr: pc_wr, undef: cond_ok && bad,
                rd_wr: wr_rd, fetches: fetches, internal: internal};
    end
  end

  // ****************************************************
  // Run timer: busy for the instruction's cycle cost
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      run_cnt <= 5'h00;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state   <= ST_RUN;
            run_cnt <= total;
            busy    <= 1'b1;
            done    <= 1'b0;
          end
        end
        default: begin
          run_cnt <= run_cnt - 5'h01;
          if (run_cnt == 5'h01) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule // asd_datapath
`default_nettype wire

// >>> asd_dp_sva.sv
`timescale 1ns/10ps
`default_nettype none
module asd_dp_sva #(parameter int unsigned FETCH_CYCLES = 1) (
  // Bus and status ports of the datapath
  input wire logic        pclk, presetn, psel, penable, pwrite, busy,
  input wire logic        pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] pwdata, prdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted start; busy bounds hold for one cycle per fetch only
  wire acc = psel && penable && pready;
  wire go  = acc && pwrite && paddr == 8'h00 && pstrb[0] && pwdata[0] && !busy;
  wire one = FETCH_CYCLES == 1;
  // Condition as the datapath holds it when a later start arrives
  logic cond_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cond_q <= 1'b1;
    else if (acc && pwrite && paddr == 8'h00 && pstrb[0])
      cond_q <= pwdata[1];
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("long ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_rd0; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("stray data");
  property p_map; acc && paddr > 8'h24 |-> pslverr; endproperty
  a_map: assert property (p_map) else $error("no error");
  property p_go; go |=> busy; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_skip; one && go && !cond_q |=> busy ##1 !busy; endproperty
  a_skip: assert property (p_skip) else $error("skip long");
  property p_len; one && $rose(busy) |-> ##[1:4] !busy; endproperty
  a_len: assert property (p_len) else $error("busy long");
  c_go: cover property (go);
  c_err: cover property (pslverr);
  c_two: cover property (busy [*2]);
endmodule // asd_dp_sva
bind asd_datapath asd_dp_sva #(.FETCH_CYCLES(FETCH_CYCLES)) i_sva (.pclk,
  .presetn, .psel, .penable, .pwrite, .busy, .pready, .pslverr, .paddr,
  .pstrb, .pwdata, .prdata);
`default_nettype wire

// >>> asd_apb_mst.sv
`timescale 1ns/10ps
`default_nettype none
module asd_apb_mst (
  // Clock and answer in, request out
  input wire logic    pclk, pready,
  output logic        psel, penable, pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb
);
  // Idle from time zero; every byte lane enabled
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  assign pstrb = 4'hF;
  // Request held until pready is sampled; gives up after 50 cycles
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output bit ok);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge pclk);
      ok = pready === 1'b1;
    end
    // Released lines flip so stale values never pass
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule // asd_apb_mst
`default_nettype wire

// >>> asd_datapath_tb.sv
`timescale 1ns/10ps
`default_nettype none
module asd_datapath_tb;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, busy;
  logic [3:0]  pstrb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, ins, le [6], m = 32'h0000_00FF;
  logic [3:0]  lo [6] = '{4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [32:0] exq [$];
  int          num_errors = 0, samples_checked = 0;
  // Clock, bus partner and design
  initial forever #4 pclk = ~pclk;
  asd_apb_mst i_mst (.pclk, .pready, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb);
  asd_datapath #(.FETCH_CYCLES(1)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .busy);
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] e, g);
    samples_checked++;
    num_errors += int'(g !== e);
    if (g !== e) $display("unexpected at %0t: got %h exp %h", $time, g, e);
  endtask
  // Each read answer is matched with the oldest note
  always @(posedge pclk)
    if (pready === 1'b1 && pwrite === 1'b0)
      chk(exq.pop_front(), {pslverr, prdata});
  // A transfer with no answer within 50 cycles ends the run
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    bit ok;
    i_mst.xfer(w, a, d, ok);
    num_errors += int'(!ok);
    if (!ok) stop_test;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Operands, flags, start; then result and flags read back
  task automatic ex(input logic [31:0] i, v, input logic [4:0] f,
                    input logic [31:0] e, input logic [3:0] g);
    for (int k = 0; k < 5; k++)
      bus(1'b1, 8'(4 * k + 4), k == 0 ? i : v);
    bus(1'b1, asd_pkg::OFF_CUR_SR, {f[3:0], 28'h000_0000});
    // The start uses the condition held from an earlier write
    bus(1'b1, asd_pkg::OFF_CTRL, {30'h0000_0000, f[4], 1'b0});
    bus(1'b1, asd_pkg::OFF_CTRL, {30'h0000_0000, f[4], 1'b1});
    rd(asd_pkg::OFF_RESULT, {1'b0, e});
    rd(asd_pkg::OFF_CUR_SR, {1'b0, g, 28'h000_0000});
  endtask
  initial begin
    r = $urandom(32'h922b_50a1);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h40, 33'h1_0000_0000);
    ex(32'hE291_2001, 32'h7FFF_FFFF, 5'h10, 32'h8000_0000, 4'h9);
    ex(32'hE3B1_2101, 32'h0000_0000, 5'h11, 32'h4000_0000, 4'h1);
    ex(32'hE1B1_2023, 32'h8000_0001, 5'h10, 32'h0000_0000, 4'h6);
    ex(32'hE1B1_2063, 32'h0000_0003, 5'h12, 32'h8000_0001, 4'hA);
    ex(32'hE1B1_2473, 32'h8000_0020, 5'h10, 32'h8000_0020, 4'hA);
    ex(32'hE1B1_2493, 32'h0000_0001, 5'h13, 32'h8000_0020, 4'h3);
    ex(32'hE351_2003, 32'h0000_0003, 5'h10, 32'h8000_0020, 4'h6);
    ex(32'hE291_2001, 32'h0000_0005, 5'h03, 32'h8000_0020, 4'h3);
    ex(32'hE1B1_2203, 32'h1800_0001, 5'h10, 32'h8000_0010, 4'hA);
    ex(32'hE1B1_2043, 32'h8000_0000, 5'h10, 32'hFFFF_FFFF, 4'hA);
    ex(32'hE1B1_2413, 32'h0000_0121, 5'h12, 32'h0000_0000, 4'h4);
    ex(32'hE1B1_2433, 32'h8000_0020, 5'h10, 32'h0000_0000, 4'h6);
    ex(32'hE1B1_2453, 32'h8000_00FF, 5'h10, 32'hFFFF_FFFF, 4'hA);
    ex(32'hE1B1_2A63, 32'h0008_0014, 5'h10, 32'h8001_4000, 4'hA);
    ex(32'hE1B1_2473, 32'h0008_0014, 5'h10, 32'h8001_4000, 4'hA);
    ex(32'hE08F_2413, 32'h0000_0100, 5'h10, 32'h0000_020C, 4'h0);
    ex(32'hE1A0_200F, 32'h0000_1000, 5'h10, 32'h0000_1008, 4'h0);
    ex(32'hE1B0_F003, 32'h0000_4444, 5'h1F, 32'h0000_4444, 4'h0);
    ex(32'hE2D1_2001, 32'h0000_0005, 5'h10, 32'h0000_0003, 4'h2);
    ex(32'hE2F1_2010, 32'h0000_0005, 5'h12, 32'h0000_000B, 4'h2);
    ex(32'hE271_2000, 32'h0000_0001, 5'h10, 32'hFFFF_FFFF, 4'h8);
    ex(32'hE2B1_2001, 32'hFFFF_FFFF, 5'h12, 32'h0000_0001, 4'h2);
    ex(32'hE251_2001, 32'h8000_0000, 5'h10, 32'h7FFF_FFFF, 4'h3);
    ex(32'hE331_0480, 32'h8000_0000, 5'h11, 32'h7FFF_FFFF, 4'h7);
    r = $urandom;
    le = '{r & m, r ^ m, r | m, m, r & ~m, ~m};
    for (int k = 0; k < 6; k++) begin
      ins = {4'hE, 3'b001, lo[k], 1'b0, 8'h12, 12'h0FF};
      ex(ins, r, 5'h1F, le[k], 4'hF);
    end
    stop_test;
  end
endmodule // asd_datapath_tb
`default_nettype wire
